// ---- dv/pmrs_partner.sv ----
`timescale 1ns/1ps
module pmrs_partner #(
  parameter [3:0] LOCK = 4'h8
) (
  input wire clk, // Bench clock
  input wire rst, // Power-on reset
  input wire stby_req, // Software wants standby
  output wire osc_tick, // Oscillator cycle
  output wire sys_tick, // System clock edge
  output wire osc_src, // Oscillator selected
  output wire pll_off, // PLL powered down
  output wire pll_sel, // PLL selected
  output wire osc_sb // Oscillator in standby
);
  reg [1:0] step_reg;
  reg [3:0] lock_reg;
  reg sys_reg;
  // Software steps into standby one control at a time, backs out in reverse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      step_reg <= 2'h0;
      lock_reg <= 4'h0;
      sys_reg <= 1'b0;
    end else begin
      sys_reg <= ~sys_reg;
      if (stby_req && step_reg != 2'h3) step_reg <= step_reg + 2'h1;
      else if (!stby_req && step_reg != 2'h0) begin
        if (step_reg == 2'h1 && lock_reg != LOCK) lock_reg <= lock_reg + 4'h1;
        else begin
          step_reg <= step_reg - 2'h1;
          lock_reg <= 4'h0;
        end
      end
    end
  end
  // Oscillator runs on through reset; system clock is half of it
  assign osc_tick = 1'b1;
  assign sys_tick = sys_reg;
  assign osc_src = step_reg != 2'h0;
  assign pll_sel = step_reg == 2'h0;
  assign pll_off = step_reg >= 2'h2;
  assign osc_sb = step_reg == 2'h3;
endmodule // pmrs_partner

// ---- dv/pmrs_sva.sv ----
`timescale 1ns/1ps
`include "pmrs_map.vh"
module pmrs_sva (
  input logic CLK,
  input logic RST,
  input logic EXT_RST,
  input logic OSC_TICK,
  input logic SYS_TICK,
  input logic ANY_IRQ,
  input logic LV_IRQ,
  input logic PLL_SELECT,
  input logic [2:0] MODE,
  input logic CORE_CLK_EN,
  input logic MEM_CLK_EN,
  input logic PER_CLK_EN,
  input logic SYS_CLK_EN,
  input logic TIMER_FAST_EN,
  input logic PWM_FAST_EN,
  input logic JTAG_RST,
  input logic EXT_POR_OUT,
  input logic PERIPHERAL_RESET_OUT,
  input logic CORE_RESET_OUT
);
  logic [6:0] por_cnt;
  logic [6:0] sys_cnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ----
  // Oscillator ticks since power-on, system ticks since peripheral release
  // ----
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      por_cnt <= 7'h00;
      sys_cnt <= 7'h00;
    end else begin
      if (OSC_TICK && por_cnt != 7'h7F) por_cnt <= por_cnt + 7'h01;
      if (PERIPHERAL_RESET_OUT) sys_cnt <= 7'h00;
      else if (SYS_TICK && sys_cnt != 7'h7F) sys_cnt <= sys_cnt + 7'h01;
    end
  end
  property p_wait_gate;
    MODE == `PMRS_MODE_WAIT |-> !CORE_CLK_EN && !MEM_CLK_EN && PER_CLK_EN;
  endproperty
  a_wait_gate: assert property (p_wait_gate) else $error("wait gating wrong");
  sequence s_wait_irq;
    MODE == `PMRS_MODE_WAIT && ANY_IRQ ##1 ANY_IRQ;
  endsequence
  property p_wait_wake;
    s_wait_irq |-> ##[0:1] (MODE == `PMRS_MODE_RUN && CORE_CLK_EN);
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("no wake from wait");
  property p_stop_gate;
    MODE == `PMRS_MODE_STOP |-> !SYS_CLK_EN && !CORE_CLK_EN && !TIMER_FAST_EN && !PWM_FAST_EN;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("clocks run in stop");
  property p_stop_wake;
    MODE == `PMRS_MODE_STOP && LV_IRQ |-> ##[1:2] MODE == `PMRS_MODE_RUN;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("no wake from stop");
  property p_pdown_hold;
    (MODE == `PMRS_MODE_PDOWN && !EXT_RST) ##1 !EXT_RST
      |-> MODE == `PMRS_MODE_PDOWN && !SYS_CLK_EN && !PER_CLK_EN;
  endproperty
  a_pdown_hold: assert property (p_pdown_hold) else $error("left power-down");
  property p_fast_gate;
    !PLL_SELECT [*3] |-> !TIMER_FAST_EN && !PWM_FAST_EN;
  endproperty
  a_fast_gate: assert property (p_fast_gate) else $error("fast clock w/o PLL");
  property p_jtag_por;
    !RST ##1 !RST |-> !JTAG_RST;
  endproperty
  a_jtag_por: assert property (p_jtag_por) else $error("test reset w/o POR");
  property p_por_len;
    $fell(EXT_POR_OUT) |-> por_cnt >= 7'h3F && por_cnt <= 7'h43;
  endproperty
  a_por_len: assert property (p_por_len) else $error("POR stretch length");
  property p_core_len;
    $fell(CORE_RESET_OUT) |-> sys_cnt >= 7'h1E && sys_cnt <= 7'h22;
  endproperty
  a_core_len: assert property (p_core_len) else $error("core release delay");
endmodule // pmrs_sva
bind pmrs_sequencer pmrs_sva u_sva (.CLK, .RST, .EXT_RST, .OSC_TICK, .SYS_TICK, .ANY_IRQ,
  .LV_IRQ, .PLL_SELECT, .MODE, .CORE_CLK_EN, .MEM_CLK_EN, .PER_CLK_EN, .SYS_CLK_EN,
  .TIMER_FAST_EN, .PWM_FAST_EN, .JTAG_RST, .EXT_POR_OUT, .PERIPHERAL_RESET_OUT,
  .CORE_RESET_OUT);

// ---- dv/test_pmrs_sequencer.sv ----
`timescale 1ns/1ps
`include "pmrs_map.vh"
module test_pmrs_sequencer;
  reg CLK = 1'b0;
  reg RST = 1'b1, EXT_RST = 1'b0, SW_RST = 1'b0, WDOG_RST = 1'b0, stby_req = 1'b0;
  reg WAIT_EXEC = 1'b0, STOP_EXEC = 1'b0, ANY_IRQ = 1'b0, DEBUG_REQ = 1'b0, LV_IRQ = 1'b0;
  reg TIMER_STOP_IRQ = 1'b0, SERIAL_STOP_IRQ = 1'b0, OSC_POWER_OFF = 1'b0;
  reg TIMER_STOP_KEEPALIVE = 1'b0, SERIAL_STOP_KEEPALIVE = 1'b0;
  reg TIMER_FAST_CLOCK_SELECT = 1'b0, PWM_FAST_CLOCK_SELECT = 1'b0;
  reg [3:0] PER_STOP_KEEPALIVE = 4'h0;
  wire OSC_TICK, SYS_TICK, OSC_SOURCE_SELECT, PLL_POWER_OFF, PLL_SELECT, OSC_STANDBY_SELECT;
  wire CORE_CLK_EN, MEM_CLK_EN, PER_CLK_EN, SYS_CLK_EN, STBY_BUS_TICK, WDOG_TICK;
  wire TIMER_FAST_EN, PWM_FAST_EN, STANDBY, REG_STBY_OK, JTAG_RST, EXT_POR_OUT;
  wire CLOCKGEN_RESET_OUT, PERIPHERAL_RESET_OUT, CORE_RESET_OUT;
  wire [3:0] PER_KEEP_EN;
  wire [2:0] MODE;
  wire [3:0] rs = {EXT_POR_OUT, CORE_RESET_OUT, PERIPHERAL_RESET_OUT, CLOCKGEN_RESET_OUT};
  integer n_errors = 0, num_checks = 0, cyc = 0, n, i;
  pmrs_sequencer #(.NPER(4)) dut (.CLK(CLK), .RST(RST), .EXT_RST(EXT_RST), .SW_RST(SW_RST),
    .WDOG_RST(WDOG_RST), .OSC_TICK(OSC_TICK), .SYS_TICK(SYS_TICK), .WAIT_EXEC(WAIT_EXEC),
    .STOP_EXEC(STOP_EXEC), .ANY_IRQ(ANY_IRQ), .DEBUG_REQ(DEBUG_REQ),
    .TIMER_STOP_IRQ(TIMER_STOP_IRQ), .SERIAL_STOP_IRQ(SERIAL_STOP_IRQ), .LV_IRQ(LV_IRQ),
    .PER_STOP_KEEPALIVE(PER_STOP_KEEPALIVE), .TIMER_STOP_KEEPALIVE(TIMER_STOP_KEEPALIVE),
    .SERIAL_STOP_KEEPALIVE(SERIAL_STOP_KEEPALIVE), .OSC_SOURCE_SELECT(OSC_SOURCE_SELECT),
    .PLL_POWER_OFF(PLL_POWER_OFF), .PLL_SELECT(PLL_SELECT),
    .OSC_STANDBY_SELECT(OSC_STANDBY_SELECT), .OSC_POWER_OFF(OSC_POWER_OFF),
    .TIMER_FAST_CLOCK_SELECT(TIMER_FAST_CLOCK_SELECT),
    .PWM_FAST_CLOCK_SELECT(PWM_FAST_CLOCK_SELECT), .CORE_CLK_EN(CORE_CLK_EN),
    .MEM_CLK_EN(MEM_CLK_EN), .PER_CLK_EN(PER_CLK_EN), .PER_KEEP_EN(PER_KEEP_EN),
    .SYS_CLK_EN(SYS_CLK_EN), .STBY_BUS_TICK(STBY_BUS_TICK), .WDOG_TICK(WDOG_TICK),
    .TIMER_FAST_EN(TIMER_FAST_EN), .PWM_FAST_EN(PWM_FAST_EN), .MODE(MODE), .STANDBY(STANDBY),
    .REG_STBY_OK(REG_STBY_OK), .JTAG_RST(JTAG_RST), .EXT_POR_OUT(EXT_POR_OUT),
    .CLOCKGEN_RESET_OUT(CLOCKGEN_RESET_OUT), .PERIPHERAL_RESET_OUT(PERIPHERAL_RESET_OUT),
    .CORE_RESET_OUT(CORE_RESET_OUT));
  pmrs_partner pm (.clk(CLK), .rst(RST), .stby_req(stby_req), .osc_tick(OSC_TICK),
    .sys_tick(SYS_TICK), .osc_src(OSC_SOURCE_SELECT), .pll_off(PLL_POWER_OFF),
    .pll_sel(PLL_SELECT), .osc_sb(OSC_STANDBY_SELECT));
  // ----
  // Clock, watchdog on the run, helpers
  // ----
  initial forever #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge CLK);
      #1;
    end
  endtask
  // Issue a stop (s=1) or wait instruction pulse
  task instr(input s);
    begin
      @(posedge CLK);
      if (s) STOP_EXEC <= 1'b1;
      else WAIT_EXEC <= 1'b1;
      @(posedge CLK);
      STOP_EXEC <= 1'b0;
      WAIT_EXEC <= 1'b0;
    end
  endtask
  // Wait for reset output s to release, count cycles
  task wrel(input integer s, input integer lo, input integer hi);
    begin
      n = 0;
      while (rs[s] !== 1'b0 && n < 500) begin
        tick(1);
        n = n + 1;
      end
      chk(n >= lo && n <= hi, 1);
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    tick(19);
    chk({JTAG_RST, rs}, 5'h1F);
    @(posedge CLK) RST <= 1'b0;
    wrel(3, 64, 66);
    wrel(0, 32, 39);
    wrel(1, 30, 36);
    wrel(2, 60, 68);
    chk({JTAG_RST, EXT_POR_OUT}, 0);
    chk({CORE_CLK_EN, MEM_CLK_EN, PER_CLK_EN, SYS_CLK_EN, MODE}, 8'h78);
    for (i = 0; i < 2; i = i + 1) begin
      instr(0);
      tick(2);
      chk({MODE, CORE_CLK_EN, MEM_CLK_EN, PER_CLK_EN}, {`PMRS_MODE_WAIT, 3'h1});
      @(posedge CLK) {DEBUG_REQ, ANY_IRQ} <= 2'h1 << i;
      tick(3);
      chk({MODE, CORE_CLK_EN}, {`PMRS_MODE_RUN, 1'b1});
      @(posedge CLK) {DEBUG_REQ, ANY_IRQ} <= 2'h0;
    end
    PER_STOP_KEEPALIVE <= 4'h5;
    TIMER_STOP_IRQ <= 1'b1;
    instr(1);
    tick(4);
    chk({MODE, SYS_CLK_EN, PER_KEEP_EN}, {`PMRS_MODE_STOP, 5'h05});
    @(posedge CLK) {TIMER_STOP_KEEPALIVE, SERIAL_STOP_KEEPALIVE} <= 2'h3;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge CLK) {DEBUG_REQ, LV_IRQ, SERIAL_STOP_IRQ, TIMER_STOP_IRQ} <= 4'h0;
      instr(1);
      tick(2);
      chk(MODE, `PMRS_MODE_STOP);
      @(posedge CLK) {DEBUG_REQ, LV_IRQ, SERIAL_STOP_IRQ, TIMER_STOP_IRQ} <= 4'h1 << i;
      tick(3);
      chk(MODE, `PMRS_MODE_RUN);
    end
    @(posedge CLK) {DEBUG_REQ, LV_IRQ, SERIAL_STOP_IRQ, TIMER_STOP_IRQ} <= 4'h0;
    {TIMER_FAST_CLOCK_SELECT, PWM_FAST_CLOCK_SELECT} <= 2'h3;
    tick(3);
    chk({TIMER_FAST_EN, PWM_FAST_EN}, 2'h3);
    for (i = 0; i < 2; i = i + 1) begin
      n = 0;
      do begin
        tick(1);
        n = n + 1;
      end while (WDOG_TICK !== 1'b1 && n < 1100);
    end
    chk(n == 1024, 1);
    @(posedge CLK) stby_req <= 1'b1;
    tick(8);
    chk({STANDBY, REG_STBY_OK, TIMER_FAST_EN}, 3'h6);
    n = 0;
    repeat (20) begin
      tick(1);
      n = n + STBY_BUS_TICK;
    end
    chk(n[7:0], 8'h0A);
    instr(0);
    tick(2);
    chk({MODE, STANDBY}, {`PMRS_MODE_WAIT, 1'b1});
    @(posedge CLK) ANY_IRQ <= 1'b1;
    tick(3);
    @(posedge CLK) ANY_IRQ <= 1'b0;
    OSC_POWER_OFF <= 1'b1;
    tick(3);
    chk({MODE, SYS_CLK_EN, PER_CLK_EN, CORE_CLK_EN}, {`PMRS_MODE_PDOWN, 3'h0});
    @(posedge CLK) {ANY_IRQ, LV_IRQ, DEBUG_REQ, SW_RST} <= 4'hF;
    tick(4);
    chk(MODE, `PMRS_MODE_PDOWN);
    @(posedge CLK) {ANY_IRQ, LV_IRQ, DEBUG_REQ, SW_RST} <= 4'h0;
    EXT_RST <= 1'b1;
    OSC_POWER_OFF <= 1'b0;
    tick(2);
    chk({rs[2:0], JTAG_RST, EXT_POR_OUT}, 5'h1C);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge CLK) {WDOG_RST, SW_RST, EXT_RST} <= 3'h1 << i;
      tick(3);
      chk({rs, JTAG_RST, MODE}, {4'h7, 1'b0, `PMRS_MODE_RUN});
      @(posedge CLK) {WDOG_RST, SW_RST, EXT_RST} <= 3'h0;
      wrel(0, 32, 39);
      wrel(1, 30, 36);
      wrel(2, 60, 68);
    end
    @(posedge CLK) stby_req <= 1'b0;
    tick(20);
    chk({STANDBY, PLL_SELECT}, 2'h1);
    tally_and_finish;
  end
endmodule // test_pmrs_sequencer

// ---- rtl/pmrs_map.vh ----
`ifndef PMRS_MAP_VH
`define PMRS_MAP_VH
// Power modes
`define PMRS_MODE_RUN 3'h0
`define PMRS_MODE_WAIT 3'h1
`define PMRS_MODE_STOP 3'h2
`define PMRS_MODE_PDOWN 3'h3
// Reset stretch counts in oscillator or system-clock cycles
`define PMRS_POR_EXT_CYC 7'h40
`define PMRS_CLKGEN_CYC 7'h20
`define PMRS_PERIP_CYC 7'h20
`define PMRS_CORE_CYC 7'h20
// Watchdog prescale and standby halving
`define PMRS_WDOG_DIV 11'h400
`define PMRS_STBY_DIV 2'h2
// Reset values
`define PMRS_CNT_RST 7'h00
`endif

// ---- rtl/pmrs_sequencer.v ----
`timescale 1ns/1ps
`include "pmrs_map.vh"
module pmrs_sequencer #(
  parameter NPER = 4
) (
  input wire CLK, // Master clock
  input wire RST, // Power-on reset, async high
  input wire EXT_RST, // External reset pin, async high
  input wire SW_RST, // Software reset write strobe
  input wire WDOG_RST, // Watchdog reset request
  input wire OSC_TICK, // Relaxation oscillator cycle enable
  input wire SYS_TICK, // System clock rising-edge enable
  input wire WAIT_EXEC, // Wait instruction pulse
  input wire STOP_EXEC, // Stop instruction pulse
  input wire ANY_IRQ, // Any interrupt pending
  input wire DEBUG_REQ, // Debug-entry command
  input wire TIMER_STOP_IRQ, // Timer interrupt
  input wire SERIAL_STOP_IRQ, // Serial interrupt
  input wire LV_IRQ, // Low-voltage interrupt
  input wire [NPER-1:0] PER_STOP_KEEPALIVE, // Stop keepalive per peripheral
  input wire TIMER_STOP_KEEPALIVE, // Timer enabled in stop
  input wire SERIAL_STOP_KEEPALIVE, // Serial enabled in stop
  input wire OSC_SOURCE_SELECT, // 1: relaxation oscillator source
  input wire PLL_POWER_OFF, // PLL powered down
  input wire PLL_SELECT, // PLL output selected
  input wire OSC_STANDBY_SELECT, // Oscillator in standby
  input wire OSC_POWER_OFF, // Oscillator powered off
  input wire TIMER_FAST_CLOCK_SELECT, // Timer 3x request
  input wire PWM_FAST_CLOCK_SELECT, // PWM 3x request
  output reg CORE_CLK_EN, // Core clock enable
  output reg MEM_CLK_EN, // Memory clock enable
  output reg PER_CLK_EN, // Peripheral group clock enable
  output reg [NPER-1:0] PER_KEEP_EN, // Per-peripheral clock enable
  output reg SYS_CLK_EN, // System clock generation enable
  output reg STBY_BUS_TICK, // Standby bus tick at half oscillator
  output reg WDOG_TICK, // Watchdog clock enable
  output reg TIMER_FAST_EN, // Timer fast clock enable
  output reg PWM_FAST_EN, // PWM fast clock enable
  output reg [2:0] MODE, // Current power mode
  output reg STANDBY, // Standby configuration active
  output reg REG_STBY_OK, // Regulator standby permitted
  output reg JTAG_RST, // Test logic reset
  output reg EXT_POR_OUT, // Stretched power-on reset
  output reg CLOCKGEN_RESET_OUT, // Clock-generator reset
  output reg PERIPHERAL_RESET_OUT, // Peripheral reset
  output reg CORE_RESET_OUT // Processor reset
);

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  reg sw_hold_reg;
  reg wd_hold_reg;
  wire any_src;
  wire sync_src;

  // Synchronous sources are captured on the clock
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      sw_hold_reg <= 1'b0;
      wd_hold_reg <= 1'b0;
    end else begin
      sw_hold_reg <= SW_RST;
      wd_hold_reg <= WDOG_RST;
    end
  end

  assign sync_src = sw_hold_reg | wd_hold_reg;
  assign any_src = EXT_RST | sync_src;

  // ----------------------------------------------------------------
  // Stretched power-on reset
  // ----------------------------------------------------------------
  reg [6:0] por_cnt_reg;
  reg por_ext_reg;

  // Counts oscillator cycles after power-on release
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      por_cnt_reg <= `PMRS_CNT_RST;
      por_ext_reg <= 1'b1;
    end else if (por_ext_reg && OSC_TICK) begin
      if (por_cnt_reg == `PMRS_POR_EXT_CYC - 7'h01) begin
        por_ext_reg <= 1'b0;
      end else begin
        por_cnt_reg <= por_cnt_reg + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Staged reset chain
  // ----------------------------------------------------------------
  reg [6:0] cg_cnt_reg;
  reg cg_rst_reg;
  reg [6:0] pe_cnt_reg;
  reg pe_rst_reg;
  reg [6:0] co_cnt_reg;
  reg co_rst_reg;
  reg cg_done_reg;
  reg pe_done_reg;
  wire chain_in;

  assign chain_in = por_ext_reg | any_src;

  // Each stage restarts its count whenever a source reasserts
  // Clock-generator stage on oscillator cycles
  always @(posedge CLK or posedge RST or posedge EXT_RST) begin
    if (RST || EXT_RST) begin
      cg_cnt_reg <= `PMRS_CNT_RST;
      cg_done_reg <= 1'b0;
    end else if (chain_in) begin
      cg_cnt_reg <= `PMRS_CNT_RST;
      cg_done_reg <= 1'b0;
    end else if (!cg_done_reg && OSC_TICK) begin
      if (cg_cnt_reg == `PMRS_CLKGEN_CYC - 7'h01) begin
        cg_done_reg <= 1'b1;
      end else begin
        cg_cnt_reg <= cg_cnt_reg + 7'h01;
      end
    end
  end

  // Peripheral stage on oscillator cycles after clock-generator release
  always @(posedge CLK or posedge RST or posedge EXT_RST) begin
    if (RST || EXT_RST) begin
      pe_cnt_reg <= `PMRS_CNT_RST;
      pe_done_reg <= 1'b0;
    end else if (chain_in || cg_rst_reg) begin
      pe_cnt_reg <= `PMRS_CNT_RST;
      pe_done_reg <= 1'b0;
    end else if (!pe_done_reg && OSC_TICK) begin
      if (pe_cnt_reg == `PMRS_PERIP_CYC - 7'h01) begin
        pe_done_reg <= 1'b1;
      end else begin
        pe_cnt_reg <= pe_cnt_reg + 7'h01;
      end
    end
  end

  // Processor stage on system clocks after peripheral release
  always @(posedge CLK or posedge RST or posedge EXT_RST) begin
    if (RST || EXT_RST) begin
      co_cnt_reg <= `PMRS_CNT_RST;
      co_rst_reg <= 1'b1;
    end else if (chain_in || pe_rst_reg) begin
      co_cnt_reg <= `PMRS_CNT_RST;
      co_rst_reg <= 1'b1;
    end else if (co_rst_reg && SYS_TICK) begin
      if (co_cnt_reg == `PMRS_CORE_CYC - 7'h01) begin
        co_rst_reg <= 1'b0;
      end else begin
        co_cnt_reg <= co_cnt_reg + 7'h01;
      end
    end
  end

  // Releases land on a system-clock edge, assertion is immediate
  always @(posedge CLK or posedge RST or posedge EXT_RST) begin
    if (RST || EXT_RST) begin
      cg_rst_reg <= 1'b1;
      pe_rst_reg <= 1'b1;
    end else begin
      if (chain_in || !cg_done_reg) begin
        cg_rst_reg <= 1'b1;
      end else if (SYS_TICK) begin
        cg_rst_reg <= 1'b0;
      end
      if (chain_in || cg_rst_reg || !pe_done_reg) begin
        pe_rst_reg <= 1'b1;
      end else if (SYS_TICK) begin
        pe_rst_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power mode machine
  // ----------------------------------------------------------------
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  wire stop_wake;

  // Timer and serial stop wake sources honour their keepalive enables; low-voltage and debug always wake
  assign stop_wake = (TIMER_STOP_IRQ & TIMER_STOP_KEEPALIVE) |
                     (SERIAL_STOP_IRQ & SERIAL_STOP_KEEPALIVE) |
                     LV_IRQ | DEBUG_REQ;

  // Next mode; entries are accepted in standby as well
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      `PMRS_MODE_RUN: begin
        if (OSC_POWER_OFF && STANDBY) begin
          mode_next = `PMRS_MODE_PDOWN;
        end else if (STOP_EXEC) begin
          mode_next = `PMRS_MODE_STOP;
        end else if (WAIT_EXEC) begin
          mode_next = `PMRS_MODE_WAIT;
        end
      end
      `PMRS_MODE_WAIT: begin
        if (ANY_IRQ || DEBUG_REQ) begin
          mode_next = `PMRS_MODE_RUN;
        end
      end
      `PMRS_MODE_STOP: begin
        if (stop_wake) begin
          mode_next = `PMRS_MODE_RUN;
        end
      end
      `PMRS_MODE_PDOWN: begin
        mode_next = `PMRS_MODE_PDOWN;
      end
      default: begin
        mode_next = `PMRS_MODE_RUN;
      end
    endcase
  end

  // Any reset returns to run; power-down needs pin or power-on
  // Software and watchdog resets are ignored there, as the oscillator is off
  always @(posedge CLK or posedge RST or posedge EXT_RST) begin
    if (RST || EXT_RST) begin
      mode_reg <= `PMRS_MODE_RUN;
    end else if (sync_src && mode_reg != `PMRS_MODE_PDOWN) begin
      mode_reg <= `PMRS_MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  reg [10:0] wd_div_reg;
  reg [1:0] sb_div_reg;

  // Oscillator prescalers for watchdog and standby bus
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      wd_div_reg <= 11'h000;
      sb_div_reg <= 2'h0;
    end else if (OSC_TICK) begin
      wd_div_reg <= (wd_div_reg == `PMRS_WDOG_DIV - 11'h001) ? 11'h000 : wd_div_reg + 11'h001;
      sb_div_reg <= (sb_div_reg == `PMRS_STBY_DIV - 2'h1) ? 2'h0 : sb_div_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  wire standby_cfg;
  wire sys_on;
  wire pll_live;

  assign standby_cfg = OSC_SOURCE_SELECT & PLL_POWER_OFF & OSC_STANDBY_SELECT;
  assign sys_on = (mode_reg == `PMRS_MODE_RUN) || (mode_reg == `PMRS_MODE_WAIT);
  assign pll_live = !PLL_POWER_OFF && PLL_SELECT;

  // Core and memory clocks run only in run mode
  function core_runs;
    input [2:0] mode_val;
    begin
      core_runs = (mode_val == `PMRS_MODE_RUN);
    end
  endfunction

  // Clock enables and status follow the mode
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      CORE_CLK_EN <= 1'b0;
      MEM_CLK_EN <= 1'b0;
      PER_CLK_EN <= 1'b0;
      PER_KEEP_EN <= {NPER{1'b0}};
      SYS_CLK_EN <= 1'b0;
      STBY_BUS_TICK <= 1'b0;
      WDOG_TICK <= 1'b0;
      TIMER_FAST_EN <= 1'b0;
      PWM_FAST_EN <= 1'b0;
      MODE <= `PMRS_MODE_RUN;
      STANDBY <= 1'b0;
      REG_STBY_OK <= 1'b0;
    end else begin
      CORE_CLK_EN <= core_runs(mode_reg);
      MEM_CLK_EN <= core_runs(mode_reg);
      PER_CLK_EN <= sys_on;
      PER_KEEP_EN <= sys_on ? {NPER{1'b1}} :
                     ((mode_reg == `PMRS_MODE_STOP) ? PER_STOP_KEEPALIVE : {NPER{1'b0}});
      SYS_CLK_EN <= sys_on;
      STBY_BUS_TICK <= standby_cfg && OSC_TICK &&
                       (sb_div_reg == `PMRS_STBY_DIV - 2'h1) &&
                       (mode_reg != `PMRS_MODE_PDOWN);
      WDOG_TICK <= OSC_TICK && (wd_div_reg == `PMRS_WDOG_DIV - 11'h001) &&
                   (mode_reg != `PMRS_MODE_PDOWN);
      TIMER_FAST_EN <= TIMER_FAST_CLOCK_SELECT && pll_live && sys_on;
      PWM_FAST_EN <= PWM_FAST_CLOCK_SELECT && pll_live && sys_on;
      MODE <= mode_reg;
      STANDBY <= standby_cfg;
      REG_STBY_OK <= OSC_SOURCE_SELECT && !PLL_SELECT && standby_cfg;
    end
  end

  // Reset outputs registered; test logic follows power-on only
  // Live sources are ORed in so a new reset shows one edge after it arrives
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      JTAG_RST <= 1'b1;
      EXT_POR_OUT <= 1'b1;
      CLOCKGEN_RESET_OUT <= 1'b1;
      PERIPHERAL_RESET_OUT <= 1'b1;
      CORE_RESET_OUT <= 1'b1;
    end else begin
      JTAG_RST <= 1'b0;
      EXT_POR_OUT <= por_ext_reg;
      CLOCKGEN_RESET_OUT <= cg_rst_reg | chain_in;
      PERIPHERAL_RESET_OUT <= pe_rst_reg | chain_in;
      CORE_RESET_OUT <= co_rst_reg | chain_in;
    end
  end

endmodule // pmrs_sequencer
